// file: io_register_space_decode_tb_top.sv
// Self-checking bench for the low I/O register decoder.
// Assumes the core request contract of the decoder; software never writes reserved places.
`timescale 1ns/1ps
module io_register_space_decode_tb_top;
  import iord_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cmd_valid = 1'b0;
  iord_op_e cmd_op = IORD_OP_PORT_IN;
  logic [7:0] cmd_addr = 8'h00, cmd_wdata = 8'h00, t8ev = 8'h00, rd, v;
  logic [2:0] cmd_bit = 3'h0;
  logic cmd_ready_reg, rsp_valid_reg, rsp_skip_reg, ext_rd_reg, ext_wr_reg, sk;
  logic [7:0] rsp_rdata_reg, ext_addr_reg, ext_wdata_reg, ext_rdata, wr_addr, wr_data;
  logic [7:0] port_a_output, port_b_output, timer8_event_flags, general_scratch_zero;
  logic [7:0] port_c_direction, port_d_output, timer16_event_flags, eeprom_control;
  logic [7:0] timer_global_control, timer8_control;
  logic [7:0] t16ev = 8'h00;
  int errors = 0;
  int n_checks = 0;
  initial forever #10 clk = ~clk;
  iord_decoder DUT (.clk, .srst, .cmd_valid, .cmd_op, .cmd_addr, .cmd_bit, .cmd_wdata, .cmd_ready_reg,
    .rsp_valid_reg, .rsp_rdata_reg, .rsp_skip_reg, .port_a_pins(8'hF5), .port_b_pins(8'h3C),
    .port_c_pins(8'h00), .port_d_pins(8'h00), .timer8_events(t8ev), .timer16_events(t16ev),
    .ext_rd_reg, .ext_wr_reg, .ext_addr_reg, .ext_wdata_reg, .ext_rdata, .port_a_direction(),
    .port_a_output, .port_b_direction(), .port_b_output, .port_c_direction, .port_c_output(),
    .port_d_direction(), .port_d_output, .port_pullup_breakbefore_control(), .timer8_event_flags,
    .timer16_event_flags, .general_scratch_zero, .eeprom_control, .eeprom_data(),
    .eeprom_address_low(), .timer_global_control, .timer8_control, .timer8_count(),
    .timer8_compare_first(), .timer8_compare_second());
  iord_ext_model u_ext (.clk, .ext_rd_reg, .ext_wr_reg, .ext_addr_reg, .ext_wdata_reg, .ext_rdata,
    .wr_addr, .wr_data);
  // ----
  // Shared tasks
  // ----
  task automatic tally_and_finish;
    if (errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One request; a spare edge first, so valid never drops and rises in one step
  task automatic req(input iord_op_e op, input logic [7:0] a, input logic [2:0] b, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk);
    while (cmd_ready_reg !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    cmd_op = op;
    cmd_addr = a;
    cmd_bit = b;
    cmd_wdata = d;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    while (rsp_valid_reg !== 1'b1 && n < 12) begin
      @(negedge clk);
      n++;
    end
    if (n >= 8) begin
      errors++;
      $display("wrong value request answer expected 1 seen %b", rsp_valid_reg);
      tally_and_finish();
    end else begin
      rd = rsp_rdata_reg;
      sk = rsp_skip_reg;
    end
  endtask : req
  // ----
  // Scenarios
  // ----
  task automatic t_port;
    req(IORD_OP_PORT_OUT, 8'h05, 3'h0, 8'hA5);
    chk("port_b_output", 8'hA5, port_b_output);
    req(IORD_OP_PORT_IN, 8'h05, 3'h0, 8'h00);
    chk("port b read", 8'hA5, rd);
    req(IORD_OP_PORT_OUT, 8'h0E, 3'h0, 8'h0F);
    chk("port_a_output", 8'h0F, port_a_output);
    req(IORD_OP_PORT_IN, 8'h0C, 3'h0, 8'h00);
    chk("port a pins", 8'h05, rd);
    req(IORD_OP_PORT_IN, 8'h03, 3'h0, 8'h00);
    chk("port b pins", 8'h3C, rd);
    req(IORD_OP_PORT_IN, 8'h24, 3'h0, 8'h00);
    chk("reserved read", 8'h00, rd);
  endtask : t_port
  task automatic t_alias;
    req(IORD_OP_MEM_WRITE, 8'h3E, 3'h0, 8'h5A);
    req(IORD_OP_PORT_IN, 8'h1E, 3'h0, 8'h00);
    chk("scratch via alias", 8'h5A, rd);
    req(IORD_OP_MEM_READ, 8'h25, 3'h0, 8'h00);
    chk("port b via data", 8'hA5, rd);
    req(IORD_OP_MEM_WRITE, 8'h25, 3'h0, 8'h3C);
    chk("port_b_output", 8'h3C, port_b_output);
  endtask : t_alias
  task automatic t_bits;
    v = 8'h00;
    req(IORD_OP_PORT_OUT, 8'h1E, 3'h0, 8'h00);
    for (int i = 0; i < 8; i++) begin
      v[i] = 1'b1;
      req(IORD_OP_BIT_SET, 8'h1E, 3'(i), 8'h00);
      chk("scratch set", v, general_scratch_zero);
    end
    req(IORD_OP_BIT_CLEAR, 8'h1E, 3'h3, 8'h00);
    chk("scratch clear", 8'hF7, general_scratch_zero);
    for (int i = 0; i < 8; i++) begin
      req(IORD_OP_SKIP_ONE, 8'h1E, 3'(i), 8'h00);
      chk("skip one", 8'(i != 3), 8'(sk));
      req(IORD_OP_SKIP_ZERO, 8'h1E, 3'(i), 8'h00);
      chk("skip zero", 8'(i == 3), 8'(sk));
    end
    req(IORD_OP_PORT_OUT, 8'h20, 3'h0, 8'h00);
    req(IORD_OP_BIT_SET, 8'h20, 3'h2, 8'h00);
    req(IORD_OP_PORT_IN, 8'h20, 3'h0, 8'h00);
    chk("bit op above range", 8'h00, rd);
  endtask : t_bits
  task automatic t_flags;
    @(negedge clk);
    t8ev = 8'h07;
    @(negedge clk);
    t8ev = 8'h00;
    chk("flags raised", 8'h07, timer8_event_flags);
    req(IORD_OP_BIT_SET, 8'h15, 3'h1, 8'h00);
    chk("flag bit set", 8'h05, timer8_event_flags);
    req(IORD_OP_PORT_OUT, 8'h15, 3'h0, 8'h04);
    chk("flag write one", 8'h01, timer8_event_flags);
    req(IORD_OP_BIT_CLEAR, 8'h15, 3'h0, 8'h00);
    chk("flag bit clear", 8'h01, timer8_event_flags);
  endtask : t_flags
  task automatic t_ext;
    req(IORD_OP_MEM_WRITE, 8'h90, 3'h0, 8'hA3);
    // The responder records the strobe one edge after the answer
    @(negedge clk);
    chk("ext write addr", 8'h90, wr_addr);
    chk("ext write data", 8'hA3, wr_data);
    req(IORD_OP_MEM_READ, 8'h80, 3'h0, 8'h00);
    chk("ext read 80", 8'hDA, rd);
    req(IORD_OP_MEM_READ, 8'hFF, 3'h0, 8'h00);
    chk("ext read FF", 8'hA5, rd);
    req(IORD_OP_PORT_IN, 8'h60, 3'h0, 8'h00);
    chk("port in above window", 8'h00, rd);
  endtask : t_ext
  task automatic t_regs;
    t16ev = 8'hFF;
    @(negedge clk);
    t16ev = 8'h00;
    chk("timer16_event_flags", 8'h27, timer16_event_flags);
    req(IORD_OP_PORT_OUT, 8'h16, 3'h0, 8'h21);
    chk("timer16_event_flags", 8'h06, timer16_event_flags);
    req(IORD_OP_MEM_WRITE, 8'h3F, 3'h0, 8'h3F);
    chk("eeprom_control", 8'h3F, eeprom_control);
    req(IORD_OP_PORT_OUT, 8'h23, 3'h0, 8'h81);
    chk("timer_global_control", 8'h81, timer_global_control);
    req(IORD_OP_PORT_OUT, 8'h25, 3'h0, 8'h0F);
    chk("timer8_control", 8'h0F, timer8_control);
    req(IORD_OP_BIT_SET, 8'h07, 3'h5, 8'h00);
    chk("port_c_direction", 8'h20, port_c_direction);
    req(IORD_OP_MEM_WRITE, 8'h2B, 3'h0, 8'h96);
    chk("port_d_output", 8'h96, port_d_output);
    req(IORD_OP_PORT_IN, 8'h1F, 3'h0, 8'h00);
    chk("eeprom_control read", 8'h3F, rd);
  endtask : t_regs
  initial begin
    repeat (16) @(negedge clk);
    srst = 1'b0;
    t_port();
    t_alias();
    t_bits();
    t_flags();
    t_ext();
    t_regs();
    tally_and_finish();
  end
endmodule : io_register_space_decode_tb_top

// file: iord_decoder.sv
// Low I/O register space decoder: port, bit and data-space access.
// Assumes the core holds a request for one cycle and waits on ready;
// pin inputs are asynchronous, event inputs come from the core clock.
`timescale 1ns/1ps

module iord_decoder
  import iord_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Core request
  input wire logic cmd_valid,
  input wire iord_pkg::iord_op_e cmd_op,
  input wire logic [7:0] cmd_addr,
  input wire logic [2:0] cmd_bit,
  input wire logic [7:0] cmd_wdata,
  output logic cmd_ready_reg,
  // Core answer
  output logic rsp_valid_reg,
  output logic [7:0] rsp_rdata_reg,
  output logic rsp_skip_reg,
  // Pin levels, asynchronous
  input wire logic [7:0] port_a_pins,
  input wire logic [7:0] port_b_pins,
  input wire logic [7:0] port_c_pins,
  input wire logic [7:0] port_d_pins,
  // Peripheral events, one-cycle pulses
  input wire logic [7:0] timer8_events,
  input wire logic [7:0] timer16_events,
  // Extended region strobes
  output logic ext_rd_reg,
  output logic ext_wr_reg,
  output logic [7:0] ext_addr_reg,
  output logic [7:0] ext_wdata_reg,
  input wire logic [7:0] ext_rdata,
  // Register contents toward peripherals
  output logic [7:0] port_a_direction,
  output logic [7:0] port_a_output,
  output logic [7:0] port_b_direction,
  output logic [7:0] port_b_output,
  output logic [7:0] port_c_direction,
  output logic [7:0] port_c_output,
  output logic [7:0] port_d_direction,
  output logic [7:0] port_d_output,
  output logic [7:0] port_pullup_breakbefore_control,
  output logic [7:0] timer8_event_flags,
  output logic [7:0] timer16_event_flags,
  output logic [7:0] general_scratch_zero,
  output logic [7:0] eeprom_control,
  output logic [7:0] eeprom_data,
  output logic [7:0] eeprom_address_low,
  output logic [7:0] timer_global_control,
  output logic [7:0] timer8_control,
  output logic [7:0] timer8_count,
  output logic [7:0] timer8_compare_first,
  output logic [7:0] timer8_compare_second
);
  import iord_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [31:0] pin_s1_reg;
  logic [31:0] pin_s2_reg;
  logic [31:0] pin_s3_reg;
  logic [31:0] pin_val_reg;
  logic [31:0] pin_raw;
  logic [31:0] pin_agree;
  logic [31:0] pin_val_next;
  logic [7:0] pin_a_now;
  logic [7:0] pin_b_now;
  logic [7:0] pin_c_now;
  logic [7:0] pin_d_now;

  assign pin_raw = {port_d_pins, port_c_pins, port_b_pins, port_a_pins};
  assign pin_agree = ~(pin_s2_reg ^ pin_s3_reg);
  // A bit moves only once stages two and three agree
  assign pin_val_next = (pin_val_reg & ~pin_agree) | (pin_s3_reg & pin_agree);
  // Reads see only the agreed value, never a half-settled stage
  assign pin_a_now = pin_val_reg[7:0];
  assign pin_b_now = pin_val_reg[15:8];
  assign pin_c_now = pin_val_reg[23:16];
  assign pin_d_now = pin_val_reg[31:24];

  always_ff @(posedge clk) begin
    pin_s1_reg <= pin_raw;
    pin_s2_reg <= pin_s1_reg;
    pin_s3_reg <= pin_s2_reg;
    pin_val_reg <= srst ? {4{IORD_RESET_VALUE}} : pin_val_next;
  end

  // ----------------------------------------
  // Operation decode
  // ----------------------------------------
  logic op_port_out;
  logic op_bit_set;
  logic op_bit_clear;
  logic op_skip_one;
  logic op_skip_zero;
  logic op_mem_read;
  logic op_mem_write;

  assign op_port_out = (cmd_op == IORD_OP_PORT_OUT);
  assign op_bit_set = (cmd_op == IORD_OP_BIT_SET);
  assign op_bit_clear = (cmd_op == IORD_OP_BIT_CLEAR);
  assign op_skip_one = (cmd_op == IORD_OP_SKIP_ONE);
  assign op_skip_zero = (cmd_op == IORD_OP_SKIP_ZERO);
  assign op_mem_read = (cmd_op == IORD_OP_MEM_READ);
  assign op_mem_write = (cmd_op == IORD_OP_MEM_WRITE);

  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  iord_state_e state_reg;
  iord_state_e state_next;
  logic take;
  logic is_bit_op;
  logic is_port_op;
  logic is_mem_op;
  logic port_ok;
  logic bit_ok;
  logic mem_io;
  logic mem_ext;
  logic io_hit;
  logic [5:0] io_idx;
  logic [7:0] mem_idx;
  logic [7:0] bit_mask;

  assign take = cmd_valid & cmd_ready_reg;
  assign is_bit_op = op_bit_set | op_bit_clear |
                     op_skip_one | op_skip_zero;
  assign is_mem_op = op_mem_read | op_mem_write;
  assign is_port_op = ~is_mem_op;
  assign port_ok = cmd_addr <= IORD_PORT_LAST;
  assign bit_ok = cmd_addr <= IORD_BIT_LAST;
  assign mem_io = (cmd_addr >= IORD_DATA_OFFSET) & (cmd_addr < IORD_EXT_FIRST);
  assign mem_ext = cmd_addr >= IORD_EXT_FIRST;
  assign mem_idx = cmd_addr - IORD_DATA_OFFSET;
  assign io_idx = is_port_op ? cmd_addr[5:0] : mem_idx[5:0];
  // Bit ops beyond 0x1F and port ops beyond 0x3F fall through as no-ops
  assign io_hit = is_bit_op ? bit_ok : (is_port_op ? port_ok : mem_io);
  assign bit_mask = IORD_BIT_ONE << cmd_bit;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] reg_file_reg [IORD_IO_DEPTH];
  logic [7:0] t8_flags_reg;
  logic [7:0] t16_flags_reg;
  logic [7:0] t8_flags_next;
  logic [7:0] t16_flags_next;

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [7:0] cur;
  logic [7:0] cur_wmask;

  assign cur_wmask = iord_wmask(io_idx);

  always_comb begin
    case (io_idx)
      IORD_PORT_A_INPUT: cur = pin_a_now & IORD_MASK_PORT_A;
      IORD_PORT_B_INPUT: cur = pin_b_now;
      IORD_PORT_C_INPUT: cur = pin_c_now;
      IORD_PORT_D_INPUT: cur = pin_d_now;
      IORD_TIMER8_FLAGS: cur = t8_flags_reg;
      IORD_TIMER16_FLAGS: cur = t16_flags_reg;
      default: cur = reg_file_reg[io_idx] & cur_wmask;
    endcase
  end

  // ----------------------------------------
  // Write path
  // ----------------------------------------
  logic is_full_write;
  logic wr_en;
  logic [7:0] wr_val;
  logic [7:0] ones_written;
  logic [7:0] t8_clear;
  logic [7:0] t16_clear;
  logic t8_hit;
  logic t16_hit;

  assign is_full_write = op_port_out | op_mem_write;
  assign wr_en = take & io_hit &
                 (is_full_write | op_bit_set | op_bit_clear);
  // Bit ops rewrite the register from its own value with one bit changed
  assign wr_val = is_full_write ? cmd_wdata :
                  op_bit_set ? (cur | bit_mask) : (cur & ~bit_mask);
  // Flags see only the ones actually written, never the read-back value
  assign ones_written = is_full_write ? cmd_wdata :
                        op_bit_set ? bit_mask : IORD_MASK_NONE;
  assign t8_hit = wr_en & (io_idx == IORD_TIMER8_FLAGS);
  assign t16_hit = wr_en & (io_idx == IORD_TIMER16_FLAGS);
  assign t8_clear = t8_hit ? ones_written : IORD_MASK_NONE;
  assign t16_clear = t16_hit ? ones_written : IORD_MASK_NONE;
  // A new event in the clearing cycle survives
  assign t8_flags_next = ((t8_flags_reg & ~t8_clear) | timer8_events) & IORD_MASK_T8_FLAGS;
  assign t16_flags_next = ((t16_flags_reg & ~t16_clear) | timer16_events) & IORD_MASK_T16_FLAGS;

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < IORD_IO_DEPTH; i++) begin
        reg_file_reg[i] <= IORD_RESET_VALUE;
      end
    end else if (wr_en) begin
      // Reserved addresses have an empty mask, so the write is lost
      reg_file_reg[io_idx] <= wr_val & cur_wmask;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      t8_flags_reg <= IORD_RESET_VALUE;
      t16_flags_reg <= IORD_RESET_VALUE;
    end else begin
      t8_flags_reg <= t8_flags_next;
      t16_flags_reg <= t16_flags_next;
    end
  end

  // ----------------------------------------
  // Extended region sequencing
  // ----------------------------------------
  logic ext_go;
  logic ext_read_go;
  logic ext_write_go;

  assign ext_go = take & is_mem_op & mem_ext;
  assign ext_read_go = ext_go & op_mem_read;
  assign ext_write_go = ext_go & op_mem_write;

  always_comb begin
    case (state_reg)
      IORD_ST_IDLE: state_next = ext_read_go ? IORD_ST_EXT_WAIT : IORD_ST_IDLE;
      IORD_ST_EXT_WAIT: state_next = IORD_ST_IDLE;
      default: state_next = IORD_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= IORD_ST_IDLE;
      cmd_ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      // Ready drops for the one cycle the outside read takes
      cmd_ready_reg <= (state_next == IORD_ST_IDLE);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ext_rd_reg <= 1'b0;
      ext_wr_reg <= 1'b0;
      ext_addr_reg <= IORD_RESET_VALUE;
      ext_wdata_reg <= IORD_RESET_VALUE;
    end else begin
      ext_rd_reg <= ext_read_go;
      ext_wr_reg <= ext_write_go;
      if (ext_go) begin
        ext_addr_reg <= cmd_addr;
        ext_wdata_reg <= cmd_wdata;
      end
    end
  end

  // ----------------------------------------
  // Answer
  // ----------------------------------------
  logic [7:0] rd_val;
  logic sel_bit;
  logic rsp_now;
  logic [7:0] rdata_now;
  logic skip_one_now;
  logic skip_zero_now;

  // Out-of-window accesses answer zero rather than stall the core
  assign rd_val = io_hit ? cur : IORD_MASK_NONE;
  assign sel_bit = |(rd_val & bit_mask);
  assign rsp_now = take & ~ext_read_go;
  assign rdata_now = (rsp_now & ~mem_ext) ? rd_val : IORD_RESET_VALUE;
  assign skip_one_now = rsp_now & sel_bit;
  assign skip_zero_now = rsp_now & ~sel_bit;

  always_ff @(posedge clk) begin
    if (srst) begin
      rsp_valid_reg <= 1'b0;
      rsp_rdata_reg <= IORD_RESET_VALUE;
      rsp_skip_reg <= 1'b0;
    end else if (state_reg == IORD_ST_EXT_WAIT) begin
      rsp_valid_reg <= 1'b1;
      rsp_rdata_reg <= ext_rdata;
      rsp_skip_reg <= 1'b0;
    end else begin
      rsp_valid_reg <= rsp_now;
      rsp_rdata_reg <= rdata_now;
      case (cmd_op)
        IORD_OP_SKIP_ONE: rsp_skip_reg <= skip_one_now;
        IORD_OP_SKIP_ZERO: rsp_skip_reg <= skip_zero_now;
        default: rsp_skip_reg <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // Register contents toward peripherals
  // ----------------------------------------
  assign port_a_direction = reg_file_reg[IORD_PORT_A_DIRECTION];
  assign port_a_output = reg_file_reg[IORD_PORT_A_OUTPUT];
  assign port_b_direction = reg_file_reg[IORD_PORT_B_DIRECTION];
  assign port_b_output = reg_file_reg[IORD_PORT_B_OUTPUT];
  assign port_c_direction = reg_file_reg[IORD_PORT_C_DIRECTION];
  assign port_c_output = reg_file_reg[IORD_PORT_C_OUTPUT];
  assign port_d_direction = reg_file_reg[IORD_PORT_D_DIRECTION];
  assign port_d_output = reg_file_reg[IORD_PORT_D_OUTPUT];
  assign port_pullup_breakbefore_control = reg_file_reg[IORD_PULLUP_CONTROL];
  assign timer8_event_flags = t8_flags_reg;
  assign timer16_event_flags = t16_flags_reg;
  assign general_scratch_zero = reg_file_reg[IORD_SCRATCH_ZERO];
  assign eeprom_control = reg_file_reg[IORD_EEPROM_CONTROL];
  assign eeprom_data = reg_file_reg[IORD_EEPROM_DATA];
  assign eeprom_address_low = reg_file_reg[IORD_EEPROM_ADDR_LOW];
  assign timer_global_control = reg_file_reg[IORD_TIMER_GLOBAL];
  assign timer8_control = reg_file_reg[IORD_TIMER8_CONTROL];
  assign timer8_count = reg_file_reg[IORD_TIMER8_COUNT];
  assign timer8_compare_first = reg_file_reg[IORD_TIMER8_CMP_FIRST];
  assign timer8_compare_second = reg_file_reg[IORD_TIMER8_CMP_SECOND];

endmodule : iord_decoder

// file: iord_decoder_properties.sv
// Port-level checks for the low I/O register decoder.
// Assumes it is bound to iord_decoder and sees only its ports.
`timescale 1ns/1ps
module iord_decoder_properties
  import iord_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Core side
  input wire logic cmd_valid,
  input wire iord_pkg::iord_op_e cmd_op,
  input wire logic [7:0] cmd_addr,
  input wire logic [2:0] cmd_bit,
  input wire logic [7:0] cmd_wdata,
  input wire logic cmd_ready_reg,
  input wire logic rsp_valid_reg,
  input wire logic [7:0] rsp_rdata_reg,
  input wire logic rsp_skip_reg,
  // Events, strobes and watched registers
  input wire logic [7:0] timer8_events,
  input wire logic ext_rd_reg,
  input wire logic ext_wr_reg,
  input wire logic [7:0] ext_addr_reg,
  input wire logic [7:0] port_b_output,
  input wire logic [7:0] timer8_event_flags,
  input wire logic [7:0] general_scratch_zero
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  wire logic take = cmd_valid && cmd_ready_reg;
  wire logic ext_hit = cmd_addr >= IORD_EXT_FIRST;
  wire logic mem_op = cmd_op == IORD_OP_MEM_READ || cmd_op == IORD_OP_MEM_WRITE;
  // ----
  // Extended read: strobe during one dead cycle, then answer
  // ----
  sequence ext_read_taken;
    take && cmd_op == IORD_OP_MEM_READ && ext_hit;
  endsequence
  sequence ext_read_answer;
    ext_rd_reg && !cmd_ready_reg && !rsp_valid_reg ##1 rsp_valid_reg && cmd_ready_reg;
  endsequence
  AST_EXT_READ: assert property (ext_read_taken |=> ext_read_answer)
    else $error("extended read out of step");
  AST_EXT_WRITE: assert property (take && cmd_op == IORD_OP_MEM_WRITE && ext_hit |=> ext_wr_reg && ext_addr_reg == $past(cmd_addr))
    else $error("extended write strobe missing");
  AST_NO_EXT_PORT: assert property (take && !mem_op |=> !ext_rd_reg && !ext_wr_reg)
    else $error("port or bit op reached extended region");
  AST_ANSWER: assert property (take && !(cmd_op == IORD_OP_MEM_READ && ext_hit) |=> rsp_valid_reg)
    else $error("no answer one cycle after request");
  AST_SKIP_ONE: assert property (take && cmd_op == IORD_OP_SKIP_ONE && cmd_addr <= IORD_BIT_LAST |=> rsp_skip_reg == rsp_rdata_reg[$past(cmd_bit)])
    else $error("skip on one wrong");
  AST_SKIP_ZERO: assert property (take && cmd_op == IORD_OP_SKIP_ZERO && cmd_addr <= IORD_BIT_LAST |=> rsp_skip_reg != rsp_rdata_reg[$past(cmd_bit)])
    else $error("skip on zero wrong");
  AST_BIT_SET: assert property (take && cmd_op == IORD_OP_BIT_SET && cmd_addr == 8'h1E |=> general_scratch_zero == ($past(general_scratch_zero) | (IORD_BIT_ONE << $past(cmd_bit))))
    else $error("bit set changed wrong bits");
  AST_BIT_CLEAR: assert property (take && cmd_op == IORD_OP_BIT_CLEAR && cmd_addr == 8'h1E |=> general_scratch_zero == ($past(general_scratch_zero) & ~(IORD_BIT_ONE << $past(cmd_bit))))
    else $error("bit clear changed wrong bits");
  AST_FLAG_W1C: assert property (take && cmd_op == IORD_OP_BIT_SET && cmd_addr == 8'h15 && timer8_events == 8'h00 |=> timer8_event_flags == ($past(timer8_event_flags) & ~(IORD_BIT_ONE << $past(cmd_bit))))
    else $error("flag clear by one wrong");
  AST_ALIAS: assert property (take && cmd_op == IORD_OP_MEM_WRITE && cmd_addr == 8'h25 |=> port_b_output == $past(cmd_wdata))
    else $error("data-space alias missed");
  AST_RESERVED_READ: assert property (take && cmd_op == IORD_OP_PORT_IN && cmd_addr == 8'h24 |=> rsp_rdata_reg == 8'h00)
    else $error("reserved location read nonzero");
endmodule : iord_decoder_properties

bind iord_decoder iord_decoder_properties u_props (.*);

// file: iord_ext_model.sv
// Responder for the extended region behind the decoder.
// Assumes read data is taken one cycle after the read strobe.
`timescale 1ns/1ps
module iord_ext_model (
  // Clock
  input wire logic clk,
  // Strobes from the decoder
  input wire logic ext_rd_reg,
  input wire logic ext_wr_reg,
  input wire logic [7:0] ext_addr_reg,
  input wire logic [7:0] ext_wdata_reg,
  // Answer and record
  output logic [7:0] ext_rdata,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data
);
  logic [7:0] junk = 8'h00;
  // Moving pattern outside strobes, so a late sample cannot pass
  assign ext_rdata = ext_rd_reg ? (ext_addr_reg ^ 8'h5A) : junk;
  always_ff @(posedge clk) begin
    junk <= junk + 8'h3B;
    if (ext_wr_reg) begin
      wr_addr <= ext_addr_reg;
      wr_data <= ext_wdata_reg;
    end
  end
endmodule : iord_ext_model

// file: iord_pkg.sv
// Constants, op codes and access masks for the low I/O register decoder.
// Assumes an 8-bit core issuing one register access per request.
package iord_pkg;

  // ----------------------------------------
  // Address windows
  // ----------------------------------------
  localparam logic [7:0] IORD_PORT_LAST = 8'h3F;
  localparam logic [7:0] IORD_BIT_LAST = 8'h1F;
  localparam logic [7:0] IORD_DATA_OFFSET = 8'h20;
  localparam logic [7:0] IORD_EXT_FIRST = 8'h60;
  localparam int IORD_IO_DEPTH = 64;

  // ----------------------------------------
  // Register offsets (port addresses)
  // ----------------------------------------
  localparam logic [5:0] IORD_PORT_B_INPUT = 6'h03;
  localparam logic [5:0] IORD_PORT_B_DIRECTION = 6'h04;
  localparam logic [5:0] IORD_PORT_B_OUTPUT = 6'h05;
  localparam logic [5:0] IORD_PORT_C_INPUT = 6'h06;
  localparam logic [5:0] IORD_PORT_C_DIRECTION = 6'h07;
  localparam logic [5:0] IORD_PORT_C_OUTPUT = 6'h08;
  localparam logic [5:0] IORD_PORT_D_INPUT = 6'h09;
  localparam logic [5:0] IORD_PORT_D_DIRECTION = 6'h0A;
  localparam logic [5:0] IORD_PORT_D_OUTPUT = 6'h0B;
  localparam logic [5:0] IORD_PORT_A_INPUT = 6'h0C;
  localparam logic [5:0] IORD_PORT_A_DIRECTION = 6'h0D;
  localparam logic [5:0] IORD_PORT_A_OUTPUT = 6'h0E;
  localparam logic [5:0] IORD_PULLUP_CONTROL = 6'h12;
  localparam logic [5:0] IORD_TIMER8_FLAGS = 6'h15;
  localparam logic [5:0] IORD_TIMER16_FLAGS = 6'h16;
  localparam logic [5:0] IORD_SCRATCH_ZERO = 6'h1E;
  localparam logic [5:0] IORD_EEPROM_CONTROL = 6'h1F;
  localparam logic [5:0] IORD_EEPROM_DATA = 6'h20;
  localparam logic [5:0] IORD_EEPROM_ADDR_LOW = 6'h21;
  localparam logic [5:0] IORD_TIMER_GLOBAL = 6'h23;
  localparam logic [5:0] IORD_TIMER8_CONTROL = 6'h25;
  localparam logic [5:0] IORD_TIMER8_COUNT = 6'h26;
  localparam logic [5:0] IORD_TIMER8_CMP_FIRST = 6'h27;
  localparam logic [5:0] IORD_TIMER8_CMP_SECOND = 6'h28;

  // ----------------------------------------
  // Field masks and reset values
  // ----------------------------------------
  localparam logic [7:0] IORD_MASK_FULL = 8'hFF;
  localparam logic [7:0] IORD_MASK_NONE = 8'h00;
  localparam logic [7:0] IORD_MASK_PORT_A = 8'h0F;
  localparam logic [7:0] IORD_MASK_T8_FLAGS = 8'h07;
  localparam logic [7:0] IORD_MASK_T16_FLAGS = 8'h27;
  localparam logic [7:0] IORD_MASK_EE_CONTROL = 8'h3F;
  localparam logic [7:0] IORD_MASK_T_GLOBAL = 8'h81;
  localparam logic [7:0] IORD_MASK_T8_CONTROL = 8'h0F;
  localparam logic [7:0] IORD_RESET_VALUE = 8'h00;
  localparam logic [7:0] IORD_BIT_ONE = 8'h01;

  // ----------------------------------------
  // Core operations and decoder states
  // ----------------------------------------
  typedef enum logic [2:0] {
    IORD_OP_PORT_IN = 3'b000,
    IORD_OP_PORT_OUT = 3'b001,
    IORD_OP_BIT_SET = 3'b010,
    IORD_OP_BIT_CLEAR = 3'b011,
    IORD_OP_SKIP_ONE = 3'b100,
    IORD_OP_SKIP_ZERO = 3'b101,
    IORD_OP_MEM_READ = 3'b110,
    IORD_OP_MEM_WRITE = 3'b111
  } iord_op_e;

  typedef enum logic [0:0] {
    IORD_ST_IDLE = 1'b0,
    IORD_ST_EXT_WAIT = 1'b1
  } iord_state_e;

  // Bits that software may store; reserved and read-only bits stay zero
  function automatic logic [7:0] iord_wmask(input logic [5:0] idx);
    logic [7:0] m;
    m = IORD_MASK_NONE;
    case (idx)
      IORD_PORT_B_DIRECTION, IORD_PORT_B_OUTPUT: m = IORD_MASK_FULL;
      IORD_PORT_C_DIRECTION, IORD_PORT_C_OUTPUT: m = IORD_MASK_FULL;
      IORD_PORT_D_DIRECTION, IORD_PORT_D_OUTPUT: m = IORD_MASK_FULL;
      IORD_PORT_A_DIRECTION, IORD_PORT_A_OUTPUT: m = IORD_MASK_PORT_A;
      IORD_PULLUP_CONTROL, IORD_SCRATCH_ZERO: m = IORD_MASK_FULL;
      IORD_EEPROM_CONTROL: m = IORD_MASK_EE_CONTROL;
      IORD_EEPROM_DATA, IORD_EEPROM_ADDR_LOW: m = IORD_MASK_FULL;
      IORD_TIMER_GLOBAL: m = IORD_MASK_T_GLOBAL;
      IORD_TIMER8_CONTROL: m = IORD_MASK_T8_CONTROL;
      IORD_TIMER8_COUNT, IORD_TIMER8_CMP_FIRST: m = IORD_MASK_FULL;
      IORD_TIMER8_CMP_SECOND: m = IORD_MASK_FULL;
      default: m = IORD_MASK_NONE;
    endcase
    return m;
  endfunction : iord_wmask

endpackage : iord_pkg
